// *** rtl/lpddr_burst_sequencing.sv ***
`timescale 1ns/1ps
`include "lpddr_defines.svh"

// Operation
// - new read burst data follows the last delivered element with no gap
// - a READ is accepted on any clock after a previous READ
// - burst stop ends a read burst after the CAS latency
// - burst stop leaves the row open
// - PRECHARGE to same bank ends a non-auto-precharge read after CAS latency
// - READ with auto precharge closes the bank BL/2 clocks later, tRAS met
// - burst lengths 2, 4, 8 and 16; a later READ interrupts or chains
// - x16 uses a low-lane and a high-lane read strobe per byte
// - x32 splits data into four byte lanes, each with its own strobe
// - WRITE carries bank, column and auto precharge closing row at burst end
// - byte stored when mask low, location untouched when mask high
// - first write element on first rising strobe, rest on every edge
// - after a write burst data pins stay off and extra data is ignored
// - a new WRITE on any clock replaces the rest of the older burst
// - first read element one or two clocks after READ per CAS latency
// - further read elements on each clock edge, strobe driven with data
// - address bit 10 with each READ or WRITE selects auto precharge
module lpddr_burst_sequencing (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // memory clock and command pins
  input wire logic ck,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [1:0] ba,
  input wire logic [`LP_ADDR_W-1:0] addr,
  // data pins
  input wire logic [`LP_DQ_W-1:0] dq_in,
  output logic [`LP_DQ_W-1:0] dq_out,
  output logic dq_oe,
  input wire logic [`LP_LANES-1:0] data_mask,
  input wire logic [`LP_LANES-1:0] lane_strobe_in,
  output logic [`LP_LANES-1:0] lane_strobe_out,
  output logic [`LP_LANES-1:0] lane_strobe_oe,
  // configuration
  input wire logic [1:0] burst_len_sel,
  input wire logic cas_lat_three,
  // status
  output logic [`LP_NUM_BANKS-1:0] bank_open,
  output logic read_active,
  output logic write_active
);

  // ========================================================
  // helpers
  function automatic logic [4:0] bl_elems(input logic [1:0] sel);
    bl_elems = `LP_MIN_BL << sel;
  endfunction

  function automatic logic [3:0] burst_col(input logic [3:0] start,
                                           input logic [3:0] idx,
                                           input logic [1:0] sel);
    logic [3:0] wrap;
    logic [3:0] sum;
    wrap = 4'(bl_elems(sel) - 5'h01);
    sum = start + idx;
    burst_col = (start & ~wrap) | (sum & wrap);
  endfunction

  // ========================================================
  // pin synchronisers
  logic [`LP_PIN_W-1:0] pin_s1_r;
  logic [`LP_PIN_W-1:0] pin_s2_r;
  logic s_ck;
  logic s_cs_n;
  logic s_ras_n;
  logic s_cas_n;
  logic s_we_n;
  logic [1:0] s_ba;
  logic [`LP_ADDR_W-1:0] s_addr;
  logic [`LP_DQ_W-1:0] s_dq;
  logic [`LP_LANES-1:0] s_dm;
  logic [`LP_LANES-1:0] s_strobe;
  logic ck_d_r;
  logic [`LP_LANES-1:0] strobe_d_r;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      ck_d_r <= 1'b0;
      strobe_d_r <= '0;
    end else begin
      pin_s1_r <= {ck, cs_n, ras_n, cas_n, we_n, ba, addr, dq_in,
                   data_mask, lane_strobe_in};
      pin_s2_r <= pin_s1_r;
      ck_d_r <= s_ck;
      strobe_d_r <= s_strobe;
    end
  end

  assign {s_ck, s_cs_n, s_ras_n, s_cas_n, s_we_n, s_ba, s_addr, s_dq,
          s_dm, s_strobe} = pin_s2_r;

  // ========================================================
  // command decode
  logic ck_rise;
  logic ck_tick;
  logic [2:0] op_w;
  logic s_a10;
  logic [3:0] s_col;
  lpddr_pkg::cmd_e cmd_w;

  assign ck_rise = s_ck && !ck_d_r;
  assign ck_tick = s_ck != ck_d_r;
  assign op_w = {s_ras_n, s_cas_n, s_we_n};
  assign s_a10 = s_addr[`LP_A10];
  assign s_col = s_addr[`LP_COL_W-1:0];
  assign cmd_w = s_cs_n ? lpddr_pkg::CMD_NOP :
                 (op_w == `LP_OP_ACT) ? lpddr_pkg::CMD_ACT :
                 (op_w == `LP_OP_READ) ? lpddr_pkg::CMD_READ :
                 (op_w == `LP_OP_WRITE) ? lpddr_pkg::CMD_WRITE :
                 (op_w == `LP_OP_BST) ? lpddr_pkg::CMD_BST :
                 (op_w == `LP_OP_PRE) ? lpddr_pkg::CMD_PRE :
                 lpddr_pkg::CMD_NOP;

  // ========================================================
  // latency pipeline, one stage per memory clock
  lpddr_pkg::cmd_e pipe_cmd_r [0:1];
  logic [1:0] pipe_ba_r [0:1];
  logic [3:0] pipe_col_r [0:1];
  logic pipe_a10_r [0:1];

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 2; i++) begin
        pipe_cmd_r[i] <= lpddr_pkg::CMD_NOP;
        pipe_ba_r[i] <= '0;
        pipe_col_r[i] <= '0;
        pipe_a10_r[i] <= 1'b0;
      end
    end else if (ck_rise) begin
      pipe_cmd_r[0] <= cmd_w;
      pipe_ba_r[0] <= s_ba;
      pipe_col_r[0] <= s_col;
      pipe_a10_r[0] <= s_a10;
      pipe_cmd_r[1] <= pipe_cmd_r[0];
      pipe_ba_r[1] <= pipe_ba_r[0];
      pipe_col_r[1] <= pipe_col_r[0];
      pipe_a10_r[1] <= pipe_a10_r[0];
    end
  end

  // ========================================================
  // read burst sequencing
  lpddr_pkg::cmd_e tap_cmd;
  lpddr_pkg::rd_state_e rd_state_r;
  lpddr_pkg::rd_state_e rd_state_nxt;
  logic [1:0] tap_ba;
  logic [3:0] tap_col;
  logic tap_a10;
  logic tap_load;
  logic tap_stop;
  logic pre_hit;
  logic [4:0] rd_cnt_r;
  logic [3:0] rd_idx_r;
  logic [3:0] rd_col_r;
  logic [1:0] rd_bank_r;
  logic [4:0] eff_cnt;
  logic [3:0] eff_idx;
  logic [3:0] eff_col;
  logic [1:0] eff_bank;
  logic rd_emit;
  logic [`LP_MEM_AW-1:0] rd_addr;
  logic [`LP_DQ_W-1:0] dq_out_r;
  logic strobe_val_r;
  logic [`LP_DQ_W-1:0] mem_r [0:`LP_MEM_DEPTH-1];

  assign tap_cmd = cas_lat_three ? pipe_cmd_r[1] : pipe_cmd_r[0];
  assign tap_ba = cas_lat_three ? pipe_ba_r[1] : pipe_ba_r[0];
  assign tap_col = cas_lat_three ? pipe_col_r[1] : pipe_col_r[0];
  assign tap_a10 = cas_lat_three ? pipe_a10_r[1] : pipe_a10_r[0];
  assign pre_hit = cas_lat_three ? (pipe_cmd_r[0] == lpddr_pkg::CMD_READ) :
                   (cmd_w == lpddr_pkg::CMD_READ);
  assign tap_load = ck_rise && (tap_cmd == lpddr_pkg::CMD_READ);
  assign tap_stop = ck_rise && ((tap_cmd == lpddr_pkg::CMD_BST) ||
                    ((tap_cmd == lpddr_pkg::CMD_PRE) &&
                     (tap_a10 || (tap_ba == rd_bank_r))));
  assign eff_cnt = tap_load ? bl_elems(burst_len_sel) :
                   tap_stop ? 5'h00 : rd_cnt_r;
  assign eff_idx = tap_load ? 4'h0 : rd_idx_r;
  assign eff_col = tap_load ? tap_col : rd_col_r;
  assign eff_bank = tap_load ? tap_ba : rd_bank_r;
  assign rd_emit = ck_tick && (eff_cnt != 5'h00);
  assign rd_addr = {eff_bank, burst_col(eff_col, eff_idx, burst_len_sel)};

  always_comb begin
    rd_state_nxt = rd_state_r;
    case (rd_state_r)
      lpddr_pkg::RD_IDLE: begin
        if (rd_emit) begin
          rd_state_nxt = lpddr_pkg::RD_DATA;
        end else if (ck_rise && pre_hit) begin
          rd_state_nxt = lpddr_pkg::RD_PRE;
        end
      end
      lpddr_pkg::RD_PRE: begin
        if (rd_emit) begin
          rd_state_nxt = lpddr_pkg::RD_DATA;
        end
      end
      lpddr_pkg::RD_DATA: begin
        if (ck_tick && !rd_emit) begin
          rd_state_nxt = lpddr_pkg::RD_POST;
        end
      end
      lpddr_pkg::RD_POST: begin
        if (rd_emit) begin
          rd_state_nxt = lpddr_pkg::RD_DATA;
        end else if (ck_tick) begin
          rd_state_nxt = lpddr_pkg::RD_IDLE;
        end
      end
      default: rd_state_nxt = lpddr_pkg::RD_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_state_r <= lpddr_pkg::RD_IDLE;
      rd_cnt_r <= '0;
      rd_idx_r <= '0;
      rd_col_r <= '0;
      rd_bank_r <= '0;
      dq_out_r <= '0;
      strobe_val_r <= 1'b0;
    end else begin
      rd_state_r <= rd_state_nxt;
      if (ck_tick) begin
        rd_cnt_r <= rd_emit ? eff_cnt - 5'h01 : eff_cnt;
        rd_idx_r <= rd_emit ? eff_idx + 4'h1 : eff_idx;
        rd_col_r <= eff_col;
        rd_bank_r <= eff_bank;
        strobe_val_r <= rd_emit && ck_rise;
      end
      if (rd_emit) begin
        dq_out_r <= mem_r[rd_addr];
      end
    end
  end

  // strobe copied to every lane, each lane times its own byte
  assign dq_out = dq_out_r;
  assign dq_oe = (rd_state_r == lpddr_pkg::RD_DATA);
  assign lane_strobe_out = {`LP_LANES{strobe_val_r}};
  assign lane_strobe_oe = {`LP_LANES{rd_state_r != lpddr_pkg::RD_IDLE}};
  assign read_active = (rd_state_r != lpddr_pkg::RD_IDLE);

  // ========================================================
  // write capture
  logic wr_pend_r;
  logic wr_fresh_r;
  logic [1:0] wr_pend_bank_r;
  logic [3:0] wr_pend_col_r;
  logic wr_pend_ap_r;
  logic [4:0] wr_cnt_r;
  logic [3:0] wr_idx_r;
  logic [3:0] wr_col_r;
  logic [1:0] wr_bank_r;
  logic wr_ap_r;
  logic [`LP_DQ_W-1:0] lane_byte_r;
  logic [`LP_LANES-1:0] lane_mask_r;
  logic el_ev_r;
  logic el_rise_r;
  logic ew_load;
  logic el_push;
  logic [4:0] ew_cnt_after;
  logic [3:0] ew_idx;
  logic [3:0] ew_col;
  logic [1:0] ew_bank;
  logic ew_ap;
  logic wr_ap_close;
  logic cap_valid_r;
  logic [`LP_ENTRY_W-1:0] cap_data_r;
  logic buf_in_ready;
  logic buf_out_valid;
  logic [`LP_ENTRY_W-1:0] buf_out_data;
  logic drain;
  logic [`LP_MEM_AW-1:0] dr_addr;
  logic [`LP_LANES-1:0] dr_mask;
  logic [`LP_DQ_W-1:0] dr_data;

  // a strobe rise seen with the WRITE itself still closes the old burst
  assign ew_load = el_ev_r && el_rise_r && wr_pend_r && !wr_fresh_r;
  assign el_push = ew_load || (el_ev_r && (wr_cnt_r != 5'h00));
  assign ew_cnt_after = ew_load ? bl_elems(burst_len_sel) - 5'h01 :
                        wr_cnt_r - 5'h01;
  assign ew_idx = ew_load ? 4'h0 : wr_idx_r;
  assign ew_col = ew_load ? wr_pend_col_r : wr_col_r;
  assign ew_bank = ew_load ? wr_pend_bank_r : wr_bank_r;
  assign ew_ap = ew_load ? wr_pend_ap_r : wr_ap_r;
  assign wr_ap_close = el_push && (ew_cnt_after == 5'h00) && ew_ap;
  assign write_active = wr_pend_r || (wr_cnt_r != 5'h00);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lane_byte_r <= '0;
      lane_mask_r <= '0;
      el_ev_r <= 1'b0;
      el_rise_r <= 1'b0;
    end else begin
      for (int l = 0; l < `LP_LANES; l++) begin
        if (s_strobe[l] != strobe_d_r[l]) begin
          lane_byte_r[8*l +: 8] <= s_dq[8*l +: 8];
          lane_mask_r[l] <= s_dm[l];
        end
      end
      el_ev_r <= s_strobe[0] != strobe_d_r[0];
      el_rise_r <= s_strobe[0] && !strobe_d_r[0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_pend_r <= 1'b0;
      wr_fresh_r <= 1'b0;
      wr_pend_bank_r <= '0;
      wr_pend_col_r <= '0;
      wr_pend_ap_r <= 1'b0;
      wr_cnt_r <= '0;
      wr_idx_r <= '0;
      wr_col_r <= '0;
      wr_bank_r <= '0;
      wr_ap_r <= 1'b0;
    end else begin
      wr_fresh_r <= ck_rise && (cmd_w == lpddr_pkg::CMD_WRITE);
      if (ck_rise && (cmd_w == lpddr_pkg::CMD_WRITE)) begin
        wr_pend_r <= 1'b1;
        wr_pend_bank_r <= s_ba;
        wr_pend_col_r <= s_col;
        wr_pend_ap_r <= s_a10;
      end else if (ew_load) begin
        wr_pend_r <= 1'b0;
      end
      if (el_push) begin
        wr_cnt_r <= ew_cnt_after;
        wr_idx_r <= ew_idx + 4'h1;
        wr_col_r <= ew_col;
        wr_bank_r <= ew_bank;
        wr_ap_r <= ew_ap;
      end
    end
  end

  // holds one element while the buffer is full
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cap_valid_r <= 1'b0;
      cap_data_r <= '0;
    end else if (el_push) begin
      cap_valid_r <= 1'b1;
      cap_data_r <= {ew_bank, burst_col(ew_col, ew_idx, burst_len_sel),
                     lane_mask_r, lane_byte_r};
    end else if (buf_in_ready) begin
      cap_valid_r <= 1'b0;
    end
  end

  lpddr_pair_buffer #(
    .W(`LP_ENTRY_W),
    .DEPTH(`LP_BUF_DEPTH)
  ) u_wbuf (
    .clk(sys_clk),
    .rst(rst),
    .in_valid(cap_valid_r),
    .in_data(cap_data_r),
    .in_ready(buf_in_ready),
    .out_valid(buf_out_valid),
    .out_data(buf_out_data),
    .out_ready(drain)
  );

  // array is single ported: a read fetch stalls the drain
  assign drain = buf_out_valid && !rd_emit;
  assign {dr_addr, dr_mask, dr_data} = buf_out_data;

  always_ff @(posedge sys_clk) begin
    if (drain) begin
      for (int l = 0; l < `LP_LANES; l++) begin
        if (!dr_mask[l]) begin
          mem_r[dr_addr][8*l +: 8] <= dr_data[8*l +: 8];
        end
      end
    end
  end

  // ========================================================
  // bank state and auto precharge
  logic [`LP_NUM_BANKS-1:0] bank_open_r;
  logic [`LP_NUM_BANKS-1:0] bank_open_nxt;
  logic [`LP_RAS_CNT_W-1:0] ras_cnt_r [0:`LP_NUM_BANKS-1];
  logic rd_ap_arm_r;
  logic [4:0] rd_ap_cnt_r;
  logic [1:0] rd_ap_bank_r;
  logic rd_ap_close;

  assign rd_ap_close = rd_ap_arm_r && (rd_ap_cnt_r == 5'h00) &&
                       (ras_cnt_r[rd_ap_bank_r] ==
                        `LP_RAS_CNT_W'(`LP_TRAS_CYC));

  always_comb begin
    bank_open_nxt = bank_open_r;
    if (rd_ap_close) begin
      bank_open_nxt[rd_ap_bank_r] = 1'b0;
    end
    if (wr_ap_close) begin
      bank_open_nxt[ew_bank] = 1'b0;
    end
    if (ck_rise && (cmd_w == lpddr_pkg::CMD_PRE)) begin
      if (s_a10) begin
        bank_open_nxt = '0;
      end else begin
        bank_open_nxt[s_ba] = 1'b0;
      end
    end
    if (ck_rise && (cmd_w == lpddr_pkg::CMD_ACT)) begin
      bank_open_nxt[s_ba] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bank_open_r <= '0;
      rd_ap_arm_r <= 1'b0;
      rd_ap_cnt_r <= '0;
      rd_ap_bank_r <= '0;
      for (int b = 0; b < `LP_NUM_BANKS; b++) begin
        ras_cnt_r[b] <= '0;
      end
    end else begin
      bank_open_r <= bank_open_nxt;
      if (ck_rise && (cmd_w == lpddr_pkg::CMD_READ) && s_a10) begin
        rd_ap_arm_r <= 1'b1;
        rd_ap_cnt_r <= bl_elems(burst_len_sel) >> 1;
        rd_ap_bank_r <= s_ba;
      end else if (ck_rise && rd_ap_arm_r && (rd_ap_cnt_r != 5'h00)) begin
        rd_ap_cnt_r <= rd_ap_cnt_r - 5'h01;
      end else if (rd_ap_close) begin
        rd_ap_arm_r <= 1'b0;
      end
      for (int b = 0; b < `LP_NUM_BANKS; b++) begin
        if (ck_rise && (cmd_w == lpddr_pkg::CMD_ACT) && (s_ba == 2'(b))) begin
          ras_cnt_r[b] <= '0;
        end else if (ras_cnt_r[b] != `LP_RAS_CNT_W'(`LP_TRAS_CYC)) begin
          ras_cnt_r[b] <= ras_cnt_r[b] + `LP_RAS_CNT_W'(1);
        end
      end
    end
  end

  assign bank_open = bank_open_r;

endmodule

// *** rtl/lpddr_defines.svh ***
`ifndef LPDDR_DEFINES_SVH
`define LPDDR_DEFINES_SVH

// ==========================================================
// sizes
`define LP_DQ_W 32
`define LP_LANES 4
`define LP_ADDR_W 11
`define LP_COL_W 4
`define LP_MEM_AW 6
`define LP_MEM_DEPTH 64
`define LP_NUM_BANKS 4
`define LP_PIN_W 58
`define LP_ENTRY_W 42
`define LP_BUF_DEPTH 2
`define LP_RAS_CNT_W 8

// ==========================================================
// command opcodes as {ras_n, cas_n, we_n}
`define LP_OP_ACT 3'h3
`define LP_OP_READ 3'h5
`define LP_OP_WRITE 3'h4
`define LP_OP_BST 3'h6
`define LP_OP_PRE 3'h2

// ==========================================================
// address fields
`define LP_A10 10

// ==========================================================
// burst length: elements = LP_MIN_BL << burst_len_sel
`define LP_MIN_BL 5'h02

// ==========================================================
// timing
`define LP_SYS_PERIOD_PS 5000
`define LP_TRAS_NS 42
`define LP_TRAS_CYC ((`LP_TRAS_NS * 1000 + `LP_SYS_PERIOD_PS - 1) / `LP_SYS_PERIOD_PS)

`endif

// *** rtl/lpddr_pkg.sv ***
package lpddr_pkg;

  // ========================================================
  // decoded commands
  typedef enum logic [2:0] {
    CMD_NOP,
    CMD_ACT,
    CMD_READ,
    CMD_WRITE,
    CMD_BST,
    CMD_PRE
  } cmd_e;

  // ========================================================
  // read output sequencing
  typedef enum logic [1:0] {
    RD_IDLE,
    RD_PRE,
    RD_DATA,
    RD_POST
  } rd_state_e;

endpackage

// *** rtl/lpddr_pair_buffer.sv ***
`timescale 1ns/1ps

module lpddr_pair_buffer #(
  parameter int W = 42,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // fill side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0] slot_r [0:DEPTH-1];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  assign in_ready = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data = slot_r[rd_ptr_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= AW'((32)'(wr_ptr_r) + 1 == DEPTH ? 0 : wr_ptr_r + 1'b1);
      end
      if (pop) begin
        rd_ptr_r <= AW'((32)'(rd_ptr_r) + 1 == DEPTH ? 0 : rd_ptr_r + 1'b1);
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      slot_r[wr_ptr_r] <= in_data;
    end
  end

endmodule

// *** sim/lpddr_burst_sequencing_chk.sv ***
`timescale 1ns/1ps
`include "lpddr_defines.svh"

// ==========================================================
// port checker
module lpddr_burst_sequencing_chk (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // command pins
  input wire logic ck,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [1:0] ba,
  input wire logic [`LP_ADDR_W-1:0] addr,
  input wire logic cas_lat_three,
  // watched outputs
  input wire logic dq_oe,
  input wire logic [`LP_LANES-1:0] lane_strobe_out,
  input wire logic [`LP_LANES-1:0] lane_strobe_oe,
  input wire logic [`LP_NUM_BANKS-1:0] bank_open,
  input wire logic read_active
);
  logic [2:0] ck_q;
  logic [1:0] bank_r;
  wire take_w = ck_q[1] & ~ck_q[2] & ~cs_n;
  wire [2:0] op_w = {ras_n, cas_n, we_n};
  wire rd_w = take_w & (op_w == `LP_OP_READ);
  wire stop_w = take_w & (op_w == `LP_OP_BST);
  wire pre_w = take_w & (op_w == `LP_OP_PRE) & ~addr[`LP_A10];

  // ==========================================================
  // ck rise finder, bank of last command
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ck_q <= 3'h0;
      bank_r <= 2'h0;
    end else begin
      ck_q <= {ck_q[1:0], ck};
      if (take_w) begin
        bank_r <= ba;
      end
    end
  end

  // ==========================================================
  // properties
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence rd_start_s;
    rd_w && !read_active;
  endsequence
  sequence preamble_s;
    !dq_oe && lane_strobe_oe == 4'hF && lane_strobe_out == 4'h0;
  endsequence

  rd_latency_a: assert property (rd_start_s |=> !dq_oe [*8])
    else $error("read data ahead of latency");
  rd_preamble_a: assert property (
    rd_start_s ##0 !cas_lat_three |-> ##[1:4] preamble_s)
    else $error("no read preamble");
  first_elem_a: assert property ($rose(dq_oe) |->
    lane_strobe_out == 4'hF && $past(lane_strobe_oe) == 4'hF)
    else $error("first element strobe wrong");
  strobe_data_a: assert property (dq_oe |-> lane_strobe_oe == 4'hF)
    else $error("data without strobe");
  lanes_equal_a: assert property (
    lane_strobe_out inside {4'h0, 4'hF} && lane_strobe_oe inside {4'h0, 4'hF})
    else $error("lane strobes differ");
  elem_hold_a: assert property (
    dq_oe && $changed(lane_strobe_out) |=> $stable(lane_strobe_out) [*4])
    else $error("element too short");
  idle_quiet_a: assert property (
    !read_active |-> !dq_oe && lane_strobe_oe == 4'h0)
    else $error("pins driven while idle");
  stop_open_a: assert property (stop_w |=> $stable(bank_open) [*6])
    else $error("burst stop changed rows");
  pre_close_a: assert property (pre_w |-> ##[1:4] !bank_open[bank_r])
    else $error("precharge left row open");
endmodule

bind lpddr_burst_sequencing lpddr_burst_sequencing_chk
  lpddr_burst_sequencing_chk_inst (
  .sys_clk(sys_clk), .rst(rst), .ck(ck), .cs_n(cs_n), .ras_n(ras_n),
  .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr),
  .cas_lat_three(cas_lat_three), .dq_oe(dq_oe),
  .lane_strobe_out(lane_strobe_out), .lane_strobe_oe(lane_strobe_oe),
  .bank_open(bank_open), .read_active(read_active));

// *** sim/lpddr_ctrl_model.sv ***
`timescale 1ns/1ps

// ==========================================================
// controller model: memory clock, commands, write strobes
module lpddr_ctrl_model (
  // clock gate
  input wire logic run,
  // memory clock and commands
  output logic ck,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [1:0] ba,
  output logic [10:0] addr,
  // write data
  output logic [31:0] dq_in,
  output logic [3:0] data_mask,
  output logic [3:0] lane_strobe_in
);
  logic [31:0] wd [0:15];
  logic [3:0] wm [0:15];

  initial begin
    ck = 1'b0;
    {cs_n, ras_n, cas_n, we_n} = 4'hF;
    ba = 2'h0;
    addr = 11'h000;
    dq_in = 32'h0000_0000;
    data_mask = 4'hF;
    lane_strobe_in = 4'h0;
  end

  always #32 ck <= run & ~ck;

  // held from falling edge until past the rising edge
  task automatic cmd(input logic [2:0] op, input logic [1:0] b,
                     input logic [10:0] a);
    @(negedge ck);
    {cs_n, ras_n, cas_n, we_n} <= {1'b0, op};
    ba <= b;
    addr <= a;
    @(posedge ck);
    #16;
    cs_n <= 1'b1;
    addr <= ~a;
  endtask

  // first rise one ck after the command, then one edge per element
  task automatic burst(input int n);
    @(negedge ck);
    @(posedge ck);
    #32;
    for (int i = 0; i < n; i++) begin
      #24;
      dq_in <= wd[i];
      data_mask <= wm[i];
      #8;
      lane_strobe_in <= {4{~i[0]}};
    end
    #24;
    dq_in <= ~dq_in;
    lane_strobe_in <= 4'h0;
  endtask
endmodule

// *** sim/lpddr_burst_sequencing_bench.sv ***
`timescale 1ns/1ps
`include "lpddr_defines.svh"

module lpddr_burst_sequencing_bench;
  logic sys_clk, rst, run, ck, cs_n, ras_n, cas_n, we_n, dq_oe;
  logic cas_lat_three, read_active, write_active;
  logic [1:0] ba, burst_len_sel;
  logic [10:0] addr;
  logic [31:0] dq_in, dq_out;
  logic [3:0] data_mask, lane_strobe_in, lane_strobe_out, lane_strobe_oe;
  logic [3:0] bank_open;
  logic [31:0] mem [0:7];
  logic [31:0] got_d [$];
  logic [3:0] got_s [$];
  int got_h [$];
  int err_count, checked, hc, cyc;

  lpddr_burst_sequencing lpddr_burst_sequencing_inst (
    .sys_clk(sys_clk), .rst(rst), .ck(ck), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe(dq_oe), .data_mask(data_mask),
    .lane_strobe_in(lane_strobe_in), .lane_strobe_out(lane_strobe_out),
    .lane_strobe_oe(lane_strobe_oe), .burst_len_sel(burst_len_sel),
    .cas_lat_three(cas_lat_three), .bank_open(bank_open),
    .read_active(read_active), .write_active(write_active));

  lpddr_ctrl_model lpddr_ctrl_model_inst (
    .run(run), .ck(ck), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .ba(ba), .addr(addr), .dq_in(dq_in),
    .data_mask(data_mask), .lane_strobe_in(lane_strobe_in));

  always #2.5 sys_clk = ~sys_clk;

  // ==========================================================
  // read element capture, mid element
  always @(ck) begin
    hc++;
    #26;
    if (dq_oe === 1'b1) begin
      got_d.push_back(dq_out);
      got_s.push_back(lane_strobe_out);
      got_h.push_back(hc);
    end
  end

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      $display("mismatch at %0t: timeout", $time);
      stop_test;
    end
  end

  // ==========================================================
  // shared tasks
  task check(input bit ok, input string msg);
    checked++;
    if (!ok) begin
      err_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  task stop_test;
    $display("compared %0d, mismatched %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task issue(input logic [2:0] op, input logic [10:0] a);
    lpddr_ctrl_model_inst.cmd(op, 2'h1, a);
  endtask

  task set_cfg(input logic [1:0] bl, input logic cl);
    @(posedge sys_clk);
    burst_len_sel <= bl;
    cas_lat_three <= cl;
  endtask

  // n elements, k-th at ck edge h0+2*lat-2+k, data checked for nd
  task rd_check(input int h0, input int n, input int lat, input int nd);
    repeat (lat + n / 2 + 3) @(posedge ck);
    check(got_d.size() == n, "element count");
    for (int k = 0; k < got_d.size(); k++) begin
      check(got_h[k] == h0 + 2 * lat - 2 + k, "element timing");
      check(got_s[k] === (k[0] ? 4'h0 : 4'hF), "strobe level");
      if (k < nd) check(got_d[k] === mem[k % 8], "read data");
    end
    got_d.delete();
    got_s.delete();
    got_h.delete();
  endtask

  // ==========================================================
  // scenarios
  task t_write;
    logic [3:0] mk [0:3];
    int h0;
    mk = '{4'h0, 4'h2, 4'hF, 4'h5};
    set_cfg(2'h0, 1'b0);
    issue(`LP_OP_READ, 11'h000);
    h0 = hc;
    issue(3'h7, 11'h000);
    set_cfg(2'h1, 1'b0);
    for (int i = 0; i < 8; i++) begin
      mem[i] = 32'hA5A5_0000 | 32'(i);
      lpddr_ctrl_model_inst.wd[i] = mem[i];
      lpddr_ctrl_model_inst.wm[i] = 4'h0;
    end
    fork
      lpddr_ctrl_model_inst.burst(8);
      begin
        issue(`LP_OP_WRITE, 11'h000);
        issue(3'h7, 11'h000);
        check(write_active === 1'b1, "write not active");
        issue(`LP_OP_WRITE, 11'h004);
      end
    join
    rd_check(h0, 2, 2, 0);
    for (int i = 0; i < 4; i++) begin
      lpddr_ctrl_model_inst.wd[i] = ~mem[i];
      lpddr_ctrl_model_inst.wm[i] = mk[i];
      for (int b = 0; b < 4; b++) begin
        if (!mk[i][b]) mem[i][8*b +: 8] = ~mem[i][8*b +: 8];
      end
    end
    fork
      lpddr_ctrl_model_inst.burst(4);
      issue(`LP_OP_WRITE, 11'h000);
    join
    issue(3'h7, 11'h000);
    check(write_active === 1'b0, "write still active");
    issue(3'h7, 11'h000);
    set_cfg(2'h2, 1'b0);
    issue(`LP_OP_READ, 11'h000);
    h0 = hc;
    rd_check(h0, 8, 2, 8);
    $display("test write done");
  endtask

  task t_chain;
    int h0;
    set_cfg(2'h1, 1'b1);
    issue(`LP_OP_READ, 11'h000);
    h0 = hc;
    issue(3'h7, 11'h000);
    issue(`LP_OP_READ, 11'h004);
    rd_check(h0, 8, 3, 8);
    $display("test chain done");
  endtask

  task t_cut;
    int h0;
    set_cfg(2'h2, 1'b0);
    issue(`LP_OP_READ, 11'h000);
    h0 = hc;
    issue(`LP_OP_BST, 11'h000);
    rd_check(h0, 2, 2, 2);
    check(bank_open[1] === 1'b1, "row closed by stop");
    issue(`LP_OP_READ, 11'h000);
    h0 = hc;
    issue(`LP_OP_PRE, 11'h000);
    rd_check(h0, 2, 2, 2);
    check(bank_open[1] === 1'b0, "row open after precharge");
    issue(3'h7, 11'h000);
    issue(`LP_OP_ACT, 11'h000);
    issue(`LP_OP_READ, 11'h400);
    h0 = hc;
    rd_check(h0, 8, 2, 8);
    check(bank_open[1] === 1'b0, "auto precharge missing");
    issue(`LP_OP_ACT, 11'h000);
    issue(`LP_OP_READ, 11'h000);
    h0 = hc;
    rd_check(h0, 8, 2, 8);
    check(bank_open[1] === 1'b1, "auto precharge persisted");
    $display("test cut done");
  endtask

  task t_lengths;
    int h0;
    int n;
    for (int s = 0; s < 4; s++) begin
      n = 2 << s;
      set_cfg(2'(s), 1'b0);
      issue(`LP_OP_READ, 11'h000);
      h0 = hc;
      rd_check(h0, n, 2, (n > 8) ? 8 : n);
    end
    $display("test lengths done");
  endtask

  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    run = 1'b0;
    burst_len_sel = 2'h1;
    cas_lat_three = 1'b0;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    run <= 1'b1;
    issue(`LP_OP_ACT, 11'h000);
    t_write;
    t_chain;
    t_cut;
    t_lengths;
    stop_test;
  end
endmodule
